// file: logic/lmp_pkg.sv
// Constants for the LED matrix PWM scan core
package lmp_pkg;
	localparam int CLK_NS = 40;
	localparam int T_SCAN_NS = 113000;
	localparam int T_NOL_NS = 7700;
	localparam int T_DLY_NS = 20;
	localparam int SCAN_CYC = T_SCAN_NS / CLK_NS;
	localparam int NOL_CYC = (T_NOL_NS + CLK_NS - 1) / CLK_NS;
	localparam int DLY_CYC = (T_DLY_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] A_DUTY_LO = 8'h01;
	localparam logic [7:0] A_DUTY0_HI = 8'hec;
	localparam logic [7:0] A_DUTY1_HI = 8'hb1;
	localparam logic [7:0] A_PAGE = 8'he7;
	localparam logic [7:0] A_LOCK = 8'he8;
	localparam logic [7:0] A_FAULT = 8'hef;
	localparam logic [7:0] A_CFG = 8'hf0;
	localparam logic [7:0] A_RESET = 8'hff;
	localparam logic [7:0] A_HI_SINK = 8'hc9;
	localparam logic [7:0] UNLOCK = 8'hc5;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] LINE_SPAN = 8'h28;
	localparam int LINES = 9;
	localparam int PAGE0_LINES = 5;
	localparam int SINKS = 48;
	localparam int LINE_SINKS = 40;
	localparam int B_SOFT_SHUTDOWN = 0;
	localparam int B_DEGHOST_MODE = 1;
	localparam int B_PWM_RES = 2;
	localparam int B_OPEN = 0;
	localparam int B_SHORT = 1;
	localparam int B_OC = 2;
	localparam int B_OT = 3;
	localparam logic [3:0] SCAN_LAST_STEP = 4'h7;
	localparam logic [3:0] SCAN_47X1 = 4'h8;
	localparam logic [3:0] SCAN_ODD4 = 4'h9;
	localparam logic [3:0] SCAN_ODD3 = 4'ha;
	localparam logic [3:0] SCAN_ODD2 = 4'hb;
	localparam logic [3:0] SCAN_STATIC = 4'hc;
	localparam logic [3:0] LINE_MAX = 4'h8;
	typedef enum logic [2:0] {S_OFF, S_GAP, S_DLY, S_ACT, S_STAT} lmp_st_t;
endpackage : lmp_pkg

// file: logic/lmp_core.sv
// LED matrix PWM scan core: duty storage, registers and scan timing
`timescale 1ns/1ps
module lmp_core (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	input wire logic os_en_in,
	input wire logic led_open_in,
	input wire logic led_short_in,
	input wire logic overcur_in,
	input wire logic overtemp_in,
	output logic [lmp_pkg::SINKS-1:0] sink_on_out,
	output logic [lmp_pkg::SINKS-1:0] deghost_out,
	output logic [lmp_pkg::LINES-1:0] sw_on_out
);
	import lmp_pkg::*;

	function automatic logic used(input logic [3:0] l, input logic [3:0] s);
		unique case (s)
			SCAN_47X1: used = (l == 4'h0);
			SCAN_ODD4: used = !l[0] && l <= 4'h6;
			SCAN_ODD3: used = !l[0] && l <= 4'h4;
			SCAN_ODD2: used = !l[0] && l <= 4'h2;
			default: used = (s <= SCAN_LAST_STEP) && (l <= LINE_MAX - s);
		endcase
	endfunction : used

	function automatic logic [3:0] nxt(input logic [3:0] l, input logic [3:0] s);
		logic [3:0] st;
		st = (s <= SCAN_LAST_STEP) ? 4'h1 : 4'h2;
		nxt = used(l + st, s) ? l + st : 4'h0;
	endfunction : nxt

	function automatic logic pwm_on(input logic [7:0] d, input logic [7:0] c,
		input logic m8);
		if (m8)
			pwm_on = c < d;
		else
			pwm_on = (c[5:0] < d[7:2]) ||
				(c[5:0] == d[7:2] && c[7:6] < d[1:0]);
	endfunction : pwm_on

	logic [7:0] duty0_q [A_DUTY_LO:A_DUTY0_HI];
	logic [7:0] duty1_q [A_DUTY_LO:A_DUTY1_HI];
	logic [7:0] cfg_q, cfg_d, rdata_q, rdata_d;
	logic [3:0] flt_q, flt_d;
	logic page_q, page_d, lock_q, lock_d;
	lmp_st_t st_q, st_d;
	logic [11:0] tmr_q, tmr_d, act_n_q;
	logic [3:0] line_q, line_d;
	logic [7:0] cnt_q;
	logic [SINKS-1:0] sink_q, sink_d, deg_q, deg_d, mask;
	logic [LINES-1:0] sw_q, sw_d, swm;
	logic wr_d0, wr_d1, soft_rst, cfg_hit, stat, run;
	logic [3:0] scan_sel;
	logic [7:0] base;

	assign scan_sel = cfg_q[7:4];
	assign stat = scan_sel >= SCAN_STATIC;
	assign run = cfg_q[B_SOFT_SHUTDOWN];
	assign wr_d0 = wr_en_in && !page_q && addr_in >= A_DUTY_LO &&
		addr_in <= A_DUTY0_HI;
	assign wr_d1 = wr_en_in && page_q && addr_in >= A_DUTY_LO &&
		addr_in <= A_DUTY1_HI;
	assign soft_rst = wr_en_in && page_q && addr_in == A_RESET;
	assign cfg_hit = soft_rst || (wr_en_in && !page_q && addr_in == A_CFG);

	// Register writes, page lock and fault flags
	always_comb begin
		cfg_d = cfg_q;
		page_d = page_q;
		lock_d = lock_q;
		flt_d = flt_q;
		rdata_d = rdata_q;
		if (soft_rst) begin
			cfg_d = RST_BYTE;
			flt_d = '0;
		end
		if (wr_en_in && !page_q && addr_in == A_CFG)
			cfg_d = wdata_in;
		if (wr_en_in && addr_in == A_LOCK)
			lock_d = wdata_in == UNLOCK;
		if (wr_en_in && addr_in == A_PAGE && lock_q) begin
			lock_d = 1'b0;
			if (wdata_in[7:1] == 7'h00)
				page_d = wdata_in[0];
		end
		// Events win over a clear in the same cycle
		if (led_open_in && os_en_in)
			flt_d[B_OPEN] = 1'b1;
		if (led_short_in && os_en_in)
			flt_d[B_SHORT] = 1'b1;
		if (overcur_in)
			flt_d[B_OC] = 1'b1;
		if (overtemp_in)
			flt_d[B_OT] = 1'b1;
		if (rd_en_in) begin
			rdata_d = RST_BYTE;
			if (addr_in == A_PAGE)
				rdata_d = {7'h00, page_q};
			else if (addr_in == A_LOCK)
				rdata_d = lock_q ? UNLOCK : RST_BYTE;
			else if (!page_q && addr_in == A_FAULT)
				rdata_d = {4'h0, flt_q};
			else if (!page_q && addr_in == A_CFG)
				rdata_d = cfg_q;
			else if (!page_q && addr_in >= A_DUTY_LO && addr_in <= A_DUTY0_HI)
				rdata_d = duty0_q[addr_in];
			else if (page_q && addr_in >= A_DUTY_LO && addr_in <= A_DUTY1_HI)
				rdata_d = duty1_q[addr_in];
		end
	end

	// Duty byte storage
	always_ff @(posedge clk_sys_in) begin
		for (int i = int'(A_DUTY_LO); i <= int'(A_DUTY0_HI); i++)
			if (rst_in || soft_rst)
				duty0_q[i] <= RST_BYTE;
			else if (wr_d0 && addr_in == 8'(i))
				duty0_q[i] <= wdata_in;
		for (int i = int'(A_DUTY_LO); i <= int'(A_DUTY1_HI); i++)
			if (rst_in || soft_rst)
				duty1_q[i] <= RST_BYTE;
			else if (wr_d1 && addr_in == 8'(i))
				duty1_q[i] <= wdata_in;
	end

	// Scan sequencer
	always_comb begin
		st_d = st_q;
		tmr_d = (tmr_q != '0) ? tmr_q - 12'h001 : tmr_q;
		line_d = line_q;
		if (!run)
			st_d = S_OFF;
		else if (stat) begin
			// Static drive reads the line-one bytes
			st_d = S_STAT;
			line_d = 4'h0;
		end else begin
			unique case (st_q)
				S_OFF, S_STAT: begin
					st_d = S_GAP;
					line_d = 4'h0;
					tmr_d = 12'(NOL_CYC - 1);
				end
				S_GAP: if (tmr_q == '0) begin
					st_d = S_DLY;
					tmr_d = 12'(DLY_CYC - 1);
				end
				S_DLY: if (tmr_q == '0) begin
					st_d = S_ACT;
					tmr_d = 12'(SCAN_CYC - 1);
				end
				S_ACT: if (tmr_q == '0) begin
					st_d = S_GAP;
					line_d = nxt(line_q, scan_sel);
					tmr_d = 12'(NOL_CYC - 1);
				end
			endcase
		end
	end

	// Sink, switch and de-ghost drive
	always_comb begin
		sink_d = '0;
		sw_d = '0;
		deg_d = '0;
		mask = {{(SINKS - LINE_SINKS){1'b0}}, {LINE_SINKS{1'b1}}};
		if (stat)
			mask = '1;
		else if (scan_sel == SCAN_47X1)
			mask = {1'b0, {(SINKS - 1){1'b1}}};
		base = A_DUTY_LO + LINE_SPAN * ((line_q >= 4'(PAGE0_LINES)) ?
			line_q - 4'(PAGE0_LINES) : line_q);
		for (int c = 0; c < LINE_SINKS; c++)
			if (st_q == S_STAT || st_q == S_ACT && used(line_q, scan_sel))
				sink_d[c] = (line_q >= 4'(PAGE0_LINES) && st_q == S_ACT) ?
					pwm_on(duty1_q[base + 8'(c)], cnt_q, cfg_q[B_PWM_RES]) :
					pwm_on(duty0_q[base + 8'(c)], cnt_q, cfg_q[B_PWM_RES]);
		for (int c = LINE_SINKS; c < SINKS; c++)
			if (mask[c] && (st_q == S_STAT || st_q == S_ACT && line_q == 4'h0))
				sink_d[c] = pwm_on(duty0_q[A_HI_SINK + 8'(c - LINE_SINKS)],
					cnt_q, cfg_q[B_PWM_RES]);
		if ((st_q == S_DLY || st_q == S_ACT) && used(line_q, scan_sel))
			sw_d[line_q] = 1'b1;
		if (!cfg_q[B_DEGHOST_MODE] && st_q == S_GAP)
			deg_d = mask;
		else if (cfg_q[B_DEGHOST_MODE] && (st_q == S_ACT || st_q == S_STAT))
			deg_d = mask & ~sink_d;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cfg_q <= RST_BYTE;
			flt_q <= '0;
			page_q <= 1'b0;
			lock_q <= 1'b0;
			rdata_q <= RST_BYTE;
			st_q <= S_OFF;
			tmr_q <= '0;
			line_q <= '0;
			cnt_q <= '0;
			sink_q <= '0;
			sw_q <= '0;
			deg_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			flt_q <= flt_d;
			page_q <= page_d;
			lock_q <= lock_d;
			rdata_q <= rdata_d;
			st_q <= st_d;
			tmr_q <= tmr_d;
			line_q <= line_d;
			cnt_q <= cnt_q + 8'h01;
			sink_q <= sink_d;
			sw_q <= sw_d;
			deg_q <= deg_d;
		end
	end

	assign rdata_out = rdata_q;
	assign sink_on_out = sink_q;
	assign deghost_out = deg_q;
	assign sw_on_out = sw_q;

	// Checks
	localparam int chk_nol = NOL_CYC;
	always_comb
		for (int l = 0; l < LINES; l++)
			swm[l] = used(4'(l), scan_sel);
	always_ff @(posedge clk_sys_in)
		act_n_q <= (st_q == S_ACT) ? act_n_q + 12'h001 : '0;
	sequence act_end;
		st_q == S_ACT && tmr_q == '0 && run && !stat;
	endsequence
	sequence gap_then_dly;
		st_q == S_GAP ##chk_nol st_q == S_DLY;
	endsequence

	chk_gap_length: assert property (@(posedge clk_sys_in)
		disable iff (rst_in || cfg_hit) act_end |=> gap_then_dly)
		else $error("gap length wrong");
	chk_active_length: assert property (@(posedge clk_sys_in)
		disable iff (rst_in || cfg_hit) act_end |-> act_n_q == 12'(SCAN_CYC - 1))
		else $error("active slot length wrong");
	chk_delay_dark: assert property (@(posedge clk_sys_in)
		disable iff (rst_in) st_q == S_DLY && swm[line_q] |=>
		sink_q == '0 && sw_q != '0)
		else $error("sink on during turn-on delay");
	chk_shutdown_dark: assert property (@(posedge clk_sys_in)
		disable iff (rst_in) !run ##1 !run |=> sink_q == '0 && sw_q == '0)
		else $error("outputs active in shutdown");
	chk_zero_duty: assert property (@(posedge clk_sys_in)
		disable iff (rst_in) st_q == S_ACT && duty0_q[1] == 8'h00 &&
		line_q == 4'h0 |=> !sink_q[0])
		else $error("zero duty lit sink");
	chk_full_duty: assert property (@(posedge clk_sys_in)
		disable iff (rst_in) st_q == S_ACT && line_q == 4'h0 &&
		cfg_q[B_PWM_RES] && duty0_q[1] == 8'hff && cnt_q != 8'hff |=> sink_q[0])
		else $error("full duty sink off");
	chk_unused_sw: assert property (@(posedge clk_sys_in)
		disable iff (rst_in) !cfg_hit |=> (sw_q & ~swm) == '0 && $onehot0(sw_q))
		else $error("unused switch line driven");
	chk_lock_once: assert property (@(posedge clk_sys_in)
		disable iff (rst_in) wr_en_in && addr_in == A_PAGE |=>
		!lock_q && (page_q == $past(lock_q && wdata_in[7:1] == 7'h00 ?
		wdata_in[0] : page_q)))
		else $error("page lock misbehaved");
	chk_open_flag: assert property (@(posedge clk_sys_in)
		disable iff (rst_in) led_open_in && os_en_in |=> flt_q[B_OPEN])
		else $error("open flag not set");
endmodule : lmp_core

// file: test/lmp_matrix_model.sv
// LED matrix partner with external switches
`timescale 1ns/1ps
module lmp_matrix_model (
	input wire logic [lmp_pkg::SINKS-1:0] sink_on_in,
	input wire logic [lmp_pkg::LINES-1:0] sw_on_in,
	input wire logic open_dot_in,
	output logic led_open_out,
	output logic overlap_out
);
	import lmp_pkg::*;
	// Open dot only shows while lit
	assign led_open_out = open_dot_in & sink_on_in[0] & sw_on_in[0];
	// Two switches on at once shorts rows
	assign overlap_out = $countones(sw_on_in) > 1;
endmodule : lmp_matrix_model

// file: test/led_matrix_pwm_scan_core_bench.sv
// Self-checking bench for the LED matrix PWM scan core
`timescale 1ns/1ps
module led_matrix_pwm_scan_core_bench;
	import lmp_pkg::*;
	logic clk_sys_in, rst_in, wr_en_in, rd_en_in, os_en_in, open_cmd;
	logic led_open_in, led_short_in, overcur_in, overtemp_in, rd_dly, overlap;
	logic [7:0] addr_in, wdata_in, rdata_out, d0, d1;
	logic [SINKS-1:0] sink_on_out, deghost_out;
	logic [LINES-1:0] sw_on_out, seen;
	logic [31:0] lfsr = 32'h5b5c0bfe;
	logic [7:0] expq[$];
	logic [3:0] fld[4] = '{SCAN_47X1, SCAN_ODD4, SCAN_ODD2, SCAN_STATIC};
	// Window per field: long enough for one whole line-one slot in the three scanned fields
	int win[4] = '{6000, 15000, 9000, 3000};
	logic [8:0] msk[4] = '{9'h001, 9'h055, 9'h005, 9'h000};
	int bad_count = 0;
	int num_checks = 0;
	int hi_run, lo_run, hi_len, lo_len, lit, lit_run, dark, clash, armed;
	lmp_core dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .rdata_out(rdata_out), .os_en_in(os_en_in),
		.led_open_in(led_open_in), .led_short_in(led_short_in),
		.overcur_in(overcur_in), .overtemp_in(overtemp_in),
		.sink_on_out(sink_on_out), .deghost_out(deghost_out),
		.sw_on_out(sw_on_out));
	lmp_matrix_model mdl (.sink_on_in(sink_on_out), .sw_on_in(sw_on_out),
		.open_dot_in(open_cmd), .led_open_out(led_open_in),
		.overlap_out(overlap));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic check(input logic [15:0] v, input logic [15:0] e);
		num_checks++;
		if (v !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, v, e);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_en_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		expq.push_back(e);
		@(posedge clk_sys_in);
		rd_en_in <= 1'b0;
	endtask : rd
	task automatic pulse(input int i);
		@(posedge clk_sys_in);
		{overtemp_in, overcur_in, led_short_in} <= 3'b001 << i;
		@(posedge clk_sys_in);
		{overtemp_in, overcur_in, led_short_in} <= 3'b000;
	endtask : pulse
	// Gathers switch pattern, run lengths and lit time of dot one
	task automatic watch(input int n);
		seen = '0;
		{lit, dark, clash, hi_run, lo_run, lit_run, hi_len, armed} = '0;
		repeat (n) begin
			@(posedge clk_sys_in);
			seen = seen | sw_on_out;
			dark += int'(sink_on_out[1]);
			clash += int'(overlap || |(deghost_out & sink_on_out));
			// Only whole line-one runs count
			if (sw_on_out[0] && armed != 0) begin
				hi_run++;
				lit_run += int'(sink_on_out[0]);
			end else if (hi_run > 0) begin
				{hi_len, lit, hi_run, lit_run} = {hi_run, lit_run, 64'd0};
			end
			armed = armed | int'(!sw_on_out[0]);
			if (sw_on_out == '0) lo_run++;
			else if (lo_run > 0) {lo_len, lo_run} = {lo_run, 32'd0};
		end
	endtask : watch
	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		if (rd_dly) check(rdata_out, expq.pop_front());
		rd_dly <= rd_en_in;
	end
	initial begin
		repeat (80000) @(posedge clk_sys_in);
		bad_count++;
		end_of_test();
	end
	initial begin
		{rst_in, wr_en_in, rd_en_in, os_en_in, open_cmd} = 5'h10;
		{led_short_in, overcur_in, overtemp_in, addr_in, wdata_in} = '0;
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd(A_CFG, RST_BYTE);
		rd(A_FAULT, RST_BYTE);
		rd(A_DUTY0_HI, RST_BYTE);
		lfsr = nxt(lfsr);
		d0 = lfsr[7:0];
		wr(A_DUTY0_HI, d0);
		wr(8'hed, 8'h5a);
		rd(A_DUTY0_HI, d0);
		rd(8'hed, 8'h00);
		wr(A_PAGE, 8'h01);
		rd(A_PAGE, 8'h00);
		wr(A_LOCK, UNLOCK);
		wr(A_PAGE, 8'h01);
		rd(A_LOCK, 8'h00);
		wr(A_PAGE, 8'h00);
		rd(A_PAGE, 8'h01);
		lfsr = nxt(lfsr);
		d1 = lfsr[7:0];
		wr(A_DUTY1_HI, d1);
		wr(8'hb2, 8'h33);
		rd(A_DUTY1_HI, d1);
		rd(8'hb2, 8'h00);
		wr(A_LOCK, UNLOCK);
		wr(A_PAGE, 8'h00);
		rd(A_DUTY0_HI, d0);
		wr(A_DUTY_LO, 8'h80);
		wr(A_CFG, 8'h74);
		watch(300);
		check(seen, 16'h0);
		wr(A_CFG, 8'h75);
		watch(9000);
		check(seen, 16'h003);
		check(16'(hi_len), 16'(DLY_CYC + SCAN_CYC));
		check(16'(lo_len), 16'(NOL_CYC));
		check(16'(lit inside {[1408:1417]}), 16'h1);
		check(16'(dark), 16'h0);
		check(16'(clash), 16'h0);
		// Full and zero duty on dot one, 8-bit, line one only
		wr(A_CFG, {SCAN_47X1, 4'h5});
		wr(A_DUTY_LO, 8'hff);
		watch(6000);
		check(16'(lit inside {[2813:2814]}), 16'h1);
		check(16'(hi_len), 16'(DLY_CYC + SCAN_CYC));
		wr(A_DUTY_LO, 8'h00);
		watch(6000);
		check(16'(lit), 16'h0);
		check(16'(hi_len), 16'(DLY_CYC + SCAN_CYC));
		wr(A_DUTY_LO, 8'h80);
		@(posedge clk_sys_in);
		open_cmd <= 1'b1;
		watch(6100);
		rd(A_FAULT, 8'h00);
		os_en_in <= 1'b1;
		watch(6100);
		rd(A_FAULT, 8'h01);
		for (int i = 0; i < 3; i++) begin
			pulse(i);
			rd(A_FAULT, 8'hff >> (6 - i));
		end
		for (int i = 0; i < 4; i++) begin
			wr(A_CFG, {fld[i], 4'h3});
			repeat (4) @(posedge clk_sys_in);
			watch(win[i]);
			check(seen, 16'(msk[i]));
			check(16'(dark), 16'h0);
			check(16'(clash), 16'h0);
			if (i < 3) check(16'(lit inside {[1408:1417]}), 16'h1);
		end
		end_of_test();
	end
endmodule : led_matrix_pwm_scan_core_bench
